// file: rtl/dsoc_pkg.sv
/*
  Constants and types shared by the deserializer strap and output configuration block.
  Assumes a single 50 MHz clock and that strap levels sit on the shared data pins during power-up.
*/
// How it works
// - Hold-low strap set keeps all parallel outputs low while link lock is high, until software release.
// - Hold-low strap clear lets outputs toggle once link lock goes high.
// - Parallel outputs stay high impedance until the device has powered up.
// - Clock slew select: 1 increased slew, 0 normal slew (default).
// - Data slew select covers 24 data and 3 control outputs; 0 is default.
// - Sleep select together with power-down input sets outputs while asleep.
// - Strobe edge select: 1 rising edge valid, 0 falling edge valid.
// - Three-bit oscillator select comes from straps and is host writable.
// - Four-bit spread range select comes from straps and is host writable.
// - Self-test enable 0 is normal operation, 1 enters self-test mode.
// - Power-down input low powers down and resets all control registers.
// - Serial bus device address is taken from the address-select input level when the straps are sampled.
// - Host may override each strap-set option by a register write.
// - All straps are sampled at power-up and again on each wake from power-down, and set the configuration.
// - Lock out is 1 when locked and active; else outputs follow sleep select.
`default_nettype none
package dsoc_pkg;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned CTRL_W = 3;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned STRAP_SETTLE_NS = 1000;
  localparam int unsigned STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_MHZ + 999) / 1000;
  // Strap positions on the shared data output pins.
  localparam int unsigned STRAP_CLK_SLEW = 21;
  localparam int unsigned STRAP_DATA_SLEW = 19;
  localparam int unsigned STRAP_SLEEP = 18;
  localparam int unsigned STRAP_EDGE = 17;
  localparam int unsigned STRAP_OSC_LSB = 8;
  localparam int unsigned STRAP_SSC_LSB = 3;
  // Bus address base; value is arbitrary.
  localparam logic [6:0] BUS_ADDR_BASE = 7'h30;
  localparam logic [11:0] CFG_RESET = 12'h000;

  typedef struct packed {
    logic       holdLow;
    logic       clkSlew;
    logic       dataSlew;
    logic       sleepSel;
    logic       strobeEdge;
    logic [2:0] oscSel;
    logic [3:0] spreadSel;
  } dsoc_cfg_t;

  typedef enum logic [2:0] {
    FLD_HOLD_LOW, FLD_CLK_SLEW, FLD_DATA_SLEW, FLD_SLEEP,
    FLD_EDGE, FLD_OSC, FLD_SPREAD, FLD_RELEASE
  } dsoc_field_t;

  typedef enum {ST_OFF, ST_SAMPLE, ST_RUN} dsoc_state_t;
endpackage
`default_nettype wire

// file: rtl/dsoc_config.sv
/*
  Strap sampling, host override and parallel output control of the deserializer.
  Assumes all inputs are synchronous to ref_clk and that the link core supplies lock, data and a clock level.
*/
`timescale 1ns/10ps
`default_nettype none
module dsoc_config
  import dsoc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = STRAP_SETTLE_CYC
)(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              power_down_n,
  input  wire logic              selftest_enable,
  input  wire logic              reserved_input,
  input  wire logic              holdLowStrap,
  input  wire logic [DATA_W-1:0] strapPins,
  input  wire logic [2:0]        addrSelLevel,
  input  wire logic              linkLocked,
  input  wire logic [DATA_W-1:0] rxData,
  input  wire logic [CTRL_W-1:0] rxCtrl,
  input  wire logic              rxClkLevel,
  input  wire logic              cfgWrEn,
  input  wire dsoc_field_t       cfgWrField,
  input  wire logic [3:0]        cfgWrData,
  output logic [DATA_W-1:0]      dataOut,
  output logic [DATA_W-1:0]      dataOutEn,
  output logic [CTRL_W-1:0]      controlOut,
  output logic [CTRL_W-1:0]      controlOutEn,
  output logic                   recoveredClockOut,
  output logic                   recoveredClockOutEn,
  output logic                   lockOut,
  output logic                   selftestMode,
  output dsoc_cfg_t              cfgOut,
  output logic [6:0]             busAddr
);

  dsoc_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  dsoc_cfg_t   strap_q, strap_d;
  dsoc_cfg_t   ovr_q, ovr_d;
  dsoc_cfg_t   mask_q, mask_d;
  logic        release_q, release_d;
  logic        seen_q, seen_d;
  logic [6:0]  addr_q, addr_d;
  dsoc_cfg_t   eff;
  dsoc_cfg_t   pinCfg;

  // Strap image as it sits on the shared pins; reserved_input is not read.
  always_comb begin
    pinCfg            = CFG_RESET;
    pinCfg.holdLow    = holdLowStrap;
    pinCfg.clkSlew    = strapPins[STRAP_CLK_SLEW];
    pinCfg.dataSlew   = strapPins[STRAP_DATA_SLEW];
    pinCfg.sleepSel   = strapPins[STRAP_SLEEP];
    pinCfg.strobeEdge = strapPins[STRAP_EDGE];
    pinCfg.oscSel     = strapPins[STRAP_OSC_LSB +: 3];
    pinCfg.spreadSel  = strapPins[STRAP_SSC_LSB +: 4];
  end

  // Written fields replace their strap values bit by bit.
  assign eff = (strap_q & ~mask_q) | (ovr_q & mask_q);

  // Sequencer, strap capture and override registers.
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    strap_d   = strap_q;
    ovr_d     = ovr_q;
    mask_d    = mask_q;
    release_d = release_q;
    seen_d    = seen_q;
    addr_d    = addr_q;
    case (state_q)
      ST_OFF: begin
        cnt_d = 16'h0000;
        if (power_down_n) begin
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        // Pins are inputs here, so the strap levels have time to settle.
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q >= 16'(SETTLE_CYC - 1)) begin
          strap_d = pinCfg;
          addr_d  = BUS_ADDR_BASE + {4'h0, addrSelLevel};
          seen_d  = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (cfgWrEn) begin
          case (cfgWrField)
            FLD_HOLD_LOW: begin
              ovr_d.holdLow  = cfgWrData[0];
              mask_d.holdLow = 1'b1;
            end
            FLD_CLK_SLEW: begin
              ovr_d.clkSlew  = cfgWrData[0];
              mask_d.clkSlew = 1'b1;
            end
            FLD_DATA_SLEW: begin
              ovr_d.dataSlew  = cfgWrData[0];
              mask_d.dataSlew = 1'b1;
            end
            FLD_SLEEP: begin
              ovr_d.sleepSel  = cfgWrData[0];
              mask_d.sleepSel = 1'b1;
            end
            FLD_EDGE: begin
              ovr_d.strobeEdge  = cfgWrData[0];
              mask_d.strobeEdge = 1'b1;
            end
            FLD_OSC: begin
              ovr_d.oscSel  = cfgWrData[2:0];
              mask_d.oscSel = 3'h7;
            end
            FLD_SPREAD: begin
              ovr_d.spreadSel  = cfgWrData;
              mask_d.spreadSel = 4'hf;
            end
            FLD_RELEASE: begin
              release_d = cfgWrData[0];
            end
            default: begin
              release_d = release_q;
            end
          endcase
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
    // Power-down wipes every control register but keeps the strap image.
    if (!power_down_n) begin
      state_d   = ST_OFF;
      ovr_d     = CFG_RESET;
      mask_d    = CFG_RESET;
      release_d = 1'b0;
      cnt_d     = 16'h0000;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q   <= ST_OFF;
      cnt_q     <= 16'h0000;
      strap_q   <= CFG_RESET;
      ovr_q     <= CFG_RESET;
      mask_q    <= CFG_RESET;
      release_q <= 1'b0;
      seen_q    <= 1'b0;
      addr_q    <= BUS_ADDR_BASE;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      strap_q   <= strap_d;
      ovr_q     <= ovr_d;
      mask_q    <= mask_d;
      release_q <= release_d;
      seen_q    <= seen_d;
      addr_q    <= addr_d;
    end
  end

  logic [DATA_W-1:0] dOut_d, dEn_d;
  logic [CTRL_W-1:0] cOut_d, cEn_d;
  logic              clk_d, clkEn_d, lock_d, bist_d;

  // Pin control. Sleep select 1 floats the pins, 0 drives them low.
  always_comb begin
    dOut_d  = '0;
    dEn_d   = '0;
    cOut_d  = '0;
    cEn_d   = '0;
    clk_d   = 1'b0;
    clkEn_d = 1'b0;
    lock_d  = 1'b0;
    bist_d  = 1'b0;
    if (state_q == ST_RUN) begin
      lock_d = linkLocked;
      bist_d = selftest_enable;
      if (!linkLocked) begin
        dEn_d   = {DATA_W{~eff.sleepSel}};
        cEn_d   = {CTRL_W{~eff.sleepSel}};
        clkEn_d = ~eff.sleepSel;
      end else if (eff.holdLow && !release_q) begin
        dEn_d   = '1;
        cEn_d   = '1;
        clkEn_d = 1'b1;
      end else begin
        dOut_d  = rxData;
        cOut_d  = rxCtrl;
        dEn_d   = '1;
        cEn_d   = '1;
        clkEn_d = 1'b1;
        clk_d   = rxClkLevel ^ ~eff.strobeEdge;
      end
    end else if (state_q == ST_OFF && seen_q) begin
      dEn_d   = {DATA_W{~eff.sleepSel}};
      cEn_d   = {CTRL_W{~eff.sleepSel}};
      clkEn_d = ~eff.sleepSel;
    end
    // Before the first completed sampling every pin stays released.
    if (!seen_q) begin
      dEn_d   = '0;
      cEn_d   = '0;
      clkEn_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dataOut             <= '0;
      dataOutEn           <= '0;
      controlOut          <= '0;
      controlOutEn        <= '0;
      recoveredClockOut   <= 1'b0;
      recoveredClockOutEn <= 1'b0;
      lockOut             <= 1'b0;
      selftestMode        <= 1'b0;
      cfgOut              <= CFG_RESET;
      busAddr             <= BUS_ADDR_BASE;
    end else begin
      dataOut             <= dOut_d;
      dataOutEn           <= dEn_d;
      controlOut          <= cOut_d;
      controlOutEn        <= cEn_d;
      recoveredClockOut   <= clk_d;
      recoveredClockOutEn <= clkEn_d;
      lockOut             <= lock_d;
      selftestMode        <= bist_d;
      cfgOut              <= eff;
      busAddr             <= addr_q;
    end
  end

  // Checks on the sequencer and pin control.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wake;
    state_q == ST_OFF && power_down_n;
  endsequence
  sequence s_settled;
    state_q == ST_SAMPLE && cnt_q >= 16'(SETTLE_CYC - 1) && power_down_n;
  endsequence
  sequence s_release;
    state_q == ST_RUN && cfgWrEn && cfgWrField == FLD_RELEASE && cfgWrData[0] && power_down_n;
  endsequence

  a_prepower_float: assert property (!seen_q |=> dataOutEn == '0)
    else $error("Pins driven before power-up.");
  a_strap_capture: assert property (s_settled |=> strap_q == $past(pinCfg) && state_q == ST_RUN)
    else $error("Strap not captured.");
  a_wake_sample: assert property (s_wake |=> state_q == ST_SAMPLE && cnt_q == 16'h0000)
    else $error("No resample on wake.");
  a_pd_clears: assert property (!power_down_n |=> mask_q == CFG_RESET && !release_q && state_q == ST_OFF)
    else $error("Power-down left control state.");
  a_hold_low: assert property (state_q == ST_RUN && linkLocked && eff.holdLow && !release_q && power_down_n
                               |=> dataOut == '0 && dataOutEn == '1)
    else $error("Hold-low not kept.");
  a_pass_data: assert property (state_q == ST_RUN && linkLocked && !eff.holdLow
                                |=> dataOut == $past(rxData) && lockOut)
    else $error("Data not passed on lock.");
  a_unlock_sleep: assert property (state_q == ST_RUN && !linkLocked |=> !lockOut && dataOutEn == {DATA_W{~$past(eff.sleepSel)}})
    else $error("Unlocked pins ignore sleep select.");
  a_write_wins: assert property (state_q == ST_RUN && cfgWrEn && cfgWrField == FLD_OSC && power_down_n
                                 |=> eff.oscSel == $past(cfgWrData[2:0]))
    else $error("Override did not take effect.");
  a_selftest_map: assert property (state_q == ST_RUN |=> selftestMode == $past(selftest_enable))
    else $error("Self-test mode mismatch.");
  a_selftest_off: assert property (state_q != ST_RUN |=> !selftestMode)
    else $error("Self-test mode outside run.");
  a_lock_follows: assert property (state_q == ST_RUN |=> lockOut == $past(linkLocked))
    else $error("Lock output does not follow lock.");

  // Asleep, the pins follow the sleep select; overrides are gone, so the strap value rules here.
  a_sleep_pins: assert property (state_q == ST_OFF && seen_q
                                 |=> dataOutEn == {DATA_W{~$past(eff.sleepSel)}} && dataOut == '0 && !lockOut)
    else $error("Sleep pins ignore sleep select.");
  // The clock is inverted for falling-edge strobing so data is stable at the chosen edge.
  a_strobe_edge: assert property (state_q == ST_RUN && linkLocked && (!eff.holdLow || release_q)
                                  |=> recoveredClockOut == ($past(eff.strobeEdge) ? $past(rxClkLevel)
                                                                                  : ~$past(rxClkLevel)))
    else $error("Clock strobe edge wrong.");
  // The address is taken with the straps, so a moving resistor level after power-up is ignored.
  a_addr_map: assert property (s_settled |=> addr_q == 7'(BUS_ADDR_BASE + {4'h0, $past(addrSelLevel)}))
    else $error("Bus address not taken from select level.");
  // A spread write lands in the effective value one edge later.
  a_spread_write: assert property (state_q == ST_RUN && cfgWrEn && cfgWrField == FLD_SPREAD && power_down_n
                                   |=> eff.spreadSel == $past(cfgWrData))
    else $error("Spread override did not take effect.");
  // Release takes one edge to register and one more to reach the pins.
  a_release_frees: assert property (s_release ##1 (state_q == ST_RUN && linkLocked)
                                    |=> dataOut == $past(rxData))
    else $error("Release did not free the outputs.");

endmodule // dsoc_config
`default_nettype wire

// file: bench/dsoc_board_model.sv
/*
  Board side of the strap block: strap resistors, address resistor and reserved pin.
  Assumes the bench changes the profile only while the device is powered down.
*/
`timescale 1ns/10ps
`default_nettype none
module dsoc_board_model (
  input  wire logic        holdLowMode,
  output logic             holdLowStrap,
  output logic [23:0]      strapPins,
  output logic [2:0]       addrSelLevel,
  output logic             reserved_input
);
  // The hold-low profile leaves every other strap at its pull-down level.
  always_comb begin
    reserved_input = 1'b0;
    holdLowStrap   = holdLowMode;
    addrSelLevel   = 3'h3;
    strapPins      = 24'h000000;
    if (!holdLowMode) begin
      strapPins = 24'h2c0550; // Clock slew, data slew, sleep, osc 5, spread a.
    end
  end
endmodule // dsoc_board_model
`default_nettype wire

// file: bench/dsoc_config_bench.sv
/*
  Self-checking bench for the strap and output configuration block.
  Assumes the board model for straps and a settle count of 2 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module dsoc_config_bench;
  import dsoc_pkg::*;
  logic ref_clk, rst_n, power_down_n, selftest_enable, reserved_input, holdLowStrap, holdLowMode;
  logic linkLocked, rxClkLevel, cfgWrEn;
  logic [23:0] strapPins, rxData, dataOut, dataOutEn;
  logic [2:0] addrSelLevel, rxCtrl, controlOut, controlOutEn;
  logic [3:0] cfgWrData;
  logic [6:0] busAddr;
  logic recoveredClockOut, recoveredClockOutEn, lockOut, selftestMode;
  dsoc_field_t cfgWrField;
  dsoc_cfg_t cfgOut, expCfg;
  int errors, comparisons, cycles;

  dsoc_board_model board (.holdLowMode(holdLowMode), .holdLowStrap(holdLowStrap), .strapPins(strapPins),
    .addrSelLevel(addrSelLevel), .reserved_input(reserved_input));
  dsoc_config #(.SETTLE_CYC(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .power_down_n(power_down_n),
    .selftest_enable(selftest_enable), .reserved_input(reserved_input), .holdLowStrap(holdLowStrap),
    .strapPins(strapPins), .addrSelLevel(addrSelLevel), .linkLocked(linkLocked), .rxData(rxData),
    .rxCtrl(rxCtrl), .rxClkLevel(rxClkLevel), .cfgWrEn(cfgWrEn), .cfgWrField(cfgWrField),
    .cfgWrData(cfgWrData), .dataOut(dataOut), .dataOutEn(dataOutEn), .controlOut(controlOut),
    .controlOutEn(controlOutEn), .recoveredClockOut(recoveredClockOut),
    .recoveredClockOutEn(recoveredClockOutEn), .lockOut(lockOut), .selftestMode(selftestMode),
    .cfgOut(cfgOut), .busAddr(busAddr));

  // Clock generator, 20 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Hang guard; the whole sequence needs well under a thousand cycles.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // One-cycle write pulse; the effect is visible two edges later, so wait three.
  task automatic wr(input dsoc_field_t f, input logic [3:0] d);
    cfgWrEn = 1'b1;
    cfgWrField = f;
    cfgWrData = d;
    waitc(1);
    cfgWrEn = 1'b0;
    waitc(3);
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    power_down_n = 1'b0;
    selftest_enable = 1'b0;
    holdLowMode = 1'b0;
    linkLocked = 1'b0;
    rxData = 24'ha5c35a;
    rxCtrl = 3'h5;
    rxClkLevel = 1'b1;
    cfgWrEn = 1'b0;
    cfgWrField = FLD_OSC;
    cfgWrData = 4'h0;
    waitc(2);
    rst_n = 1'b1;
    waitc(6);
    chk("oe before power-up", 24'h000000, dataOutEn);
    wr(FLD_OSC, 4'h2);
    $display("test unpowered done");
    power_down_n = 1'b1;
    waitc(8);
    expCfg = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'h5, 4'ha};
    chk("cfg from straps", 24'(expCfg), 24'(cfgOut));
    chk("bus address", 24'(BUS_ADDR_BASE + 7'h3), 24'(busAddr));
    chk("oe unlocked sleep", 24'h000000, dataOutEn);
    linkLocked = 1'b1;
    selftest_enable = 1'b1;
    waitc(3);
    chk("data locked", rxData, dataOut);
    chk("ctrl locked", 24'(rxCtrl), 24'(controlOut));
    chk("lock out", 24'h1, 24'(lockOut));
    chk("clock falling strobe", 24'h0, 24'(recoveredClockOut));
    chk("selftest", 24'h1, 24'(selftestMode));
    selftest_enable = 1'b0;
    $display("test straps done");
    wr(FLD_OSC, 4'h2);
    wr(FLD_SPREAD, 4'h3);
    wr(FLD_EDGE, 4'h1);
    wr(FLD_CLK_SLEW, 4'h0);
    wr(FLD_DATA_SLEW, 4'h0);
    wr(FLD_SLEEP, 4'h0);
    expCfg = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 3'h2, 4'h3};
    chk("cfg override", 24'(expCfg), 24'(cfgOut));
    chk("clock rising strobe", 24'h1, 24'(recoveredClockOut));
    chk("selftest off", 24'h0, 24'(selftestMode));
    wr(FLD_HOLD_LOW, 4'h1);
    chk("held by write", 24'h000000, dataOut);
    $display("test override done");
    power_down_n = 1'b0;
    waitc(3);
    chk("oe asleep", 24'h000000, dataOutEn);
    chk("lock asleep", 24'h0, 24'(lockOut));
    chk("ctrl oe asleep", 24'h0, 24'(controlOutEn));
    chk("clock oe asleep", 24'h0, 24'(recoveredClockOutEn));
    wr(FLD_SPREAD, 4'hf);
    power_down_n = 1'b1;
    waitc(8);
    expCfg = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'h5, 4'ha};
    chk("cfg after wake", 24'(expCfg), 24'(cfgOut));
    $display("test power-down done");
    power_down_n = 1'b0;
    linkLocked = 1'b0;
    holdLowMode = 1'b1;
    waitc(3);
    power_down_n = 1'b1;
    waitc(8);
    chk("oe unlocked drive", 24'hffffff, dataOutEn);
    linkLocked = 1'b1;
    waitc(3);
    chk("held data", 24'h000000, dataOut);
    chk("held oe", 24'hffffff, dataOutEn);
    chk("held ctrl oe", 24'h7, 24'(controlOutEn));
    chk("held clock oe", 24'h1, 24'(recoveredClockOutEn));
    wr(FLD_RELEASE, 4'h1);
    chk("released data", rxData, dataOut);
    power_down_n = 1'b0;
    waitc(3);
    chk("oe asleep low", 24'hffffff, dataOutEn);
    chk("data asleep low", 24'h000000, dataOut);
    $display("test hold-low done");
    summarize();
  end
endmodule // dsoc_config_bench
`default_nettype wire
